// ===== logic/stereo_link_pkg.sv
// Purpose: constants and types shared by the stereo serial link control files
// Assumes: 100 MHz system clock, registers addressed by their 8-bit offsets
// Notes: every offset, field position, reset value and timing count lives here
package stereo_link_pkg;

	// ****************************************************************
	// register offsets
	// ****************************************************************
	localparam logic [7:0] OFS_LATENCY = 8'hb4;
	localparam logic [7:0] OFS_SYNC = 8'hb5;
	localparam logic [7:0] OFS_PAYLOAD = 8'hb6;
	localparam logic [7:0] OFS_ERR_CTRL = 8'hb7;
	localparam logic [7:0] OFS_ERR_STAT = 8'hb8;
	localparam logic [7:0] OFS_CAPTURE = 8'hb9;
	localparam logic [7:0] OFS_GAIN = 8'hba;

	// ****************************************************************
	// field positions and widths
	// ****************************************************************
	localparam int LAT_LSB = 0;
	localparam int LAT_W = 2;
	localparam int SYNC_EN_BIT = 0;
	localparam int TEN_BIT_BIT = 0;
	localparam int ERR_DET_BIT = 0;
	localparam int ERR_STICKY_BIT = 1;
	localparam int ERR_CLEAR_BIT = 2;
	localparam int ERR_FLAG_BIT = 0;
	localparam int GAIN_W = 7;
	localparam int REG_W = 16;
	localparam int BYTE_W = 8;
	localparam int PIX_W = 10;
	localparam int FIFO_W = PIX_W + 1;
	localparam int FIFO_DEPTH = 16;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [LAT_W-1:0] RST_LATENCY = 2'h0;
	localparam logic RST_SYNC_EN = 1'b0;
	localparam logic RST_TEN_BIT = 1'b0;
	localparam logic [2:0] RST_ERR_CTRL = 3'h0;
	localparam logic [REG_W-1:0] RST_CAPTURE = 16'h0000;
	localparam logic [GAIN_W-1:0] RST_GAIN = 7'h10;

	// ****************************************************************
	// line word format and timing
	// ****************************************************************
	localparam int WORD_BITS = PIX_W + 2;
	localparam logic [PIX_W-1:0] RSV_CODE = 10'h3ff;
	localparam logic [PIX_W-1:0] CLIP_CODE = 10'h3fe;
	localparam longint CLK_HZ = 100_000_000;
	localparam longint SHIFT_HZ = 25_000_000;
	localparam int SHIFT_DIV = int'(CLK_HZ / SHIFT_HZ);

	typedef enum {SER_IDLE, SER_SHIFT} ser_state_t;

endpackage : stereo_link_pkg

// ===== logic/stream_fifo.sv
// Purpose: small flip-flop FIFO with valid/ready on both sides
// Assumes: one clock, synchronous active-high reset
// Notes: full and empty come straight from the occupancy count
`timescale 1ns/100ps
module stream_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = mem_q[rd_q];

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule : stream_fifo

// ===== logic/latency_delay.sv
// Purpose: delays the serial bit stream by one to four bit slots
// Assumes: step_i is the one-cycle shift enable of the serial line
// Notes: output is registered, so a fixed one-slot base delay always applies
`timescale 1ns/100ps
module latency_delay (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic step_i,
	input wire logic [1:0] sel_i,
	input wire logic bit_i,
	output logic bit_o
);
	logic [2:0] tap_q;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			tap_q <= '0;
			bit_o <= 1'b0;
		end else if (step_i) begin
			tap_q <= {tap_q[1:0], bit_i};
			case (sel_i)
				2'h0: bit_o <= bit_i;
				2'h1: bit_o <= tap_q[0];
				2'h2: bit_o <= tap_q[1];
				default: bit_o <= tap_q[2];
			endcase
		end
	end

endmodule : latency_delay

// ===== logic/stereo_serial_link_control.sv
// Purpose: register bank and data path for the stereo serial pixel link
// Assumes: register port, pixel source, gain loop and stereo partner receiver
//          all run on clk_i; the serial line pad is outside this block
// Notes: reads return data one cycle after reg_rd_i; unmapped offsets read zero
//
// Behaviour
// - output stream delayed by two-bit latency field
// - sync enable sends start bit then zeros
// - ten-bit mode sends all bits, embedded control
// - eight-bit mode sends eight pixel plus two control
// - error detection runs only when enabled
// - sticky mode holds error flag until clear
// - writing clear bit zeroes the error flag
// - error flag readable and driven to pin
// - capture register holds master and slave bytes
// - capture when master reserved, slave not
// - gain status seven bits, resets to sixteen
`timescale 1ns/100ps
module stereo_serial_link_control
	import stereo_link_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [REG_W-1:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [REG_W-1:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// pixel source
	input wire logic [PIX_W-1:0] pix_data_i,
	input wire logic pix_line_start_i,
	input wire logic pix_valid_i,
	output logic pix_ready_o,
	// stereo partner words, already deserialized
	input wire logic [BYTE_W-1:0] slave_byte_i,
	input wire logic slave_reserved_i,
	input wire logic slave_word_valid_i,
	// gain loop
	input wire logic [GAIN_W-1:0] automatic_gain_loop_i,
	// line and pin
	output logic serial_pixel_out_pair_o,
	output logic error_pin_o
);

	// ****************************************************************
	// control registers
	// ****************************************************************
	logic [LAT_W-1:0] latency_q;
	logic sync_en_q;
	logic ten_bit_q;
	logic err_det_q;
	logic err_sticky_q;
	logic err_clear;
	logic err_flag_q;
	logic [REG_W-1:0] capture_q;
	logic [GAIN_W-1:0] gain_q;

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction : hit
	// one decode serves every register write process and the clear strobe; the read mux has its own case

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			latency_q <= RST_LATENCY;
		end else if (reg_wr_i && hit(reg_addr_i, OFS_LATENCY)) begin
			latency_q <= reg_wdata_i[LAT_LSB +: LAT_W];
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sync_en_q <= RST_SYNC_EN;
		end else if (reg_wr_i && hit(reg_addr_i, OFS_SYNC)) begin
			sync_en_q <= reg_wdata_i[SYNC_EN_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ten_bit_q <= RST_TEN_BIT;
		end else if (reg_wr_i && hit(reg_addr_i, OFS_PAYLOAD)) begin
			ten_bit_q <= reg_wdata_i[TEN_BIT_BIT];
		end
	end

	// clear is a write strobe only; it never reads back as one
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			err_det_q <= RST_ERR_CTRL[ERR_DET_BIT];
			err_sticky_q <= RST_ERR_CTRL[ERR_STICKY_BIT];
		end else if (reg_wr_i && hit(reg_addr_i, OFS_ERR_CTRL)) begin
			err_det_q <= reg_wdata_i[ERR_DET_BIT];
			err_sticky_q <= reg_wdata_i[ERR_STICKY_BIT];
		end
	end

	assign err_clear = reg_wr_i && hit(reg_addr_i, OFS_ERR_CTRL)
		&& reg_wdata_i[ERR_CLEAR_BIT];

	// gain is sampled every cycle so the status never lags more than one cycle
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			gain_q <= RST_GAIN;
		end else begin
			gain_q <= automatic_gain_loop_i;
		end
	end

	// ****************************************************************
	// register read port
	// ****************************************************************
	logic [REG_W-1:0] rd_mux;
	// decoded in the request cycle, so a read beside a write sees the old value

	always_comb begin
		rd_mux = '0;
		case (reg_addr_i)
			OFS_LATENCY: rd_mux[LAT_LSB +: LAT_W] = latency_q;
			OFS_SYNC: rd_mux[SYNC_EN_BIT] = sync_en_q;
			OFS_PAYLOAD: rd_mux[TEN_BIT_BIT] = ten_bit_q;
			OFS_ERR_CTRL: begin
				rd_mux[ERR_DET_BIT] = err_det_q;
				rd_mux[ERR_STICKY_BIT] = err_sticky_q;
			end
			OFS_ERR_STAT: rd_mux[ERR_FLAG_BIT] = err_flag_q;
			OFS_CAPTURE: rd_mux = capture_q;
			OFS_GAIN: rd_mux[GAIN_W-1:0] = gain_q;
			default: rd_mux = '0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= '0;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			// data holds between reads, so a late look still finds it
			if (reg_rd_i) begin
				reg_rdata_o <= rd_mux;
			end
		end
	end

	// ****************************************************************
	// pixel buffer
	// ****************************************************************
	logic [FIFO_W-1:0] fifo_data;
	logic fifo_valid;
	logic fifo_take;
	// the buffer absorbs the word-rate mismatch; the source stalls once it fills

	stream_fifo #(
		.WIDTH(FIFO_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.in_data_i({pix_line_start_i, pix_data_i}),
		.in_valid_i(pix_valid_i),
		.in_ready_o(pix_ready_o),
		.out_data_o(fifo_data),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_take)
	);

	// ****************************************************************
	// shift rate divider
	// ****************************************************************
	localparam int DIV_W = $clog2(SHIFT_DIV + 1);
	logic [DIV_W-1:0] div_q;
	logic shift_en;
	// free-running divider: only reset sets the slot phase, never the data

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			div_q <= '0;
		end else if (div_q == DIV_W'(SHIFT_DIV - 1)) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	assign shift_en = (div_q == DIV_W'(SHIFT_DIV - 1));

	// ****************************************************************
	// word builder
	// ****************************************************************
	logic [PIX_W-1:0] fifo_pix;
	logic fifo_ls;
	logic [PIX_W-1:0] payload;
	logic [WORD_BITS-1:0] next_word;
	logic word_due;

	assign fifo_pix = fifo_data[PIX_W-1:0];
	assign fifo_ls = fifo_data[PIX_W];

	// in ten-bit mode, real pixels at the reserved code are clipped so control stays unambiguous
	always_comb begin
		payload = '0;
		// eight-bit mode gives up the two low pixel bits to carry control
		if (ten_bit_q) begin
			if (fifo_ls) begin
				payload = RSV_CODE;
			end else if (fifo_pix == RSV_CODE) begin
				payload = CLIP_CODE;
			end else begin
				payload = fifo_pix;
			end
		end else begin
			payload = {fifo_pix[PIX_W-1 -: BYTE_W], fifo_ls, 1'b1};
		end
	end

	always_comb begin
		next_word = '0;
		// sync outranks data and leaves the buffer untouched
		if (sync_en_q) begin
			next_word = {1'b1, {PIX_W{1'b0}}, 1'b0};
		end else if (fifo_valid) begin
			next_word = {1'b1, payload, 1'b0};
		end
	end

	// ****************************************************************
	// serializer
	// ****************************************************************
	localparam int BC_W = $clog2(WORD_BITS);
	ser_state_t state_q;
	logic [WORD_BITS-1:0] shreg_q;
	logic [BC_W-1:0] bitcnt_q;
	logic ser_bit;
	logic load;
	// words follow back to back while data lasts; an empty buffer leaves the line low

	assign word_due = shift_en && (state_q == SER_IDLE || bitcnt_q == '0);
	// while sync runs the buffer is not drained, so the source sees back-pressure
	assign fifo_take = word_due && !sync_en_q && fifo_valid;
	assign load = word_due && (sync_en_q || fifo_valid);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_q <= SER_IDLE;
			shreg_q <= '0;
			bitcnt_q <= '0;
		end else if (shift_en) begin
			case (state_q)
				SER_IDLE: begin
					if (load) begin
						shreg_q <= next_word;
						bitcnt_q <= BC_W'(WORD_BITS - 1);
						state_q <= SER_SHIFT;
					end
				end
				SER_SHIFT: begin
					if (bitcnt_q != '0) begin
						shreg_q <= {shreg_q[WORD_BITS-2:0], 1'b0};
						bitcnt_q <= bitcnt_q - 1'b1;
					end else if (load) begin
						shreg_q <= next_word;
						bitcnt_q <= BC_W'(WORD_BITS - 1);
					end else begin
						shreg_q <= '0;
						state_q <= SER_IDLE;
					end
				end
				default: state_q <= SER_IDLE;
			endcase
		end
	end

	assign ser_bit = (state_q == SER_SHIFT) ? shreg_q[WORD_BITS-1] : 1'b0;

	// a latency change mid-stream slips the line by the difference; set it while idle
	latency_delay u_delay (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.step_i(shift_en),
		.sel_i(latency_q),
		.bit_i(ser_bit),
		.bit_o(serial_pixel_out_pair_o)
	);

	// ****************************************************************
	// stereo error detection
	// ****************************************************************
	logic [BYTE_W-1:0] master_byte_q;
	logic master_rsv_q;
	logic mismatch;
	logic err_set;
	// the master flag is the last word pulled, so an idle master compares a stale word

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			master_byte_q <= '0;
			master_rsv_q <= 1'b0;
		end else if (fifo_take) begin
			master_byte_q <= fifo_pix[PIX_W-1 -: BYTE_W];
			master_rsv_q <= fifo_ls;
		end
	end

	assign mismatch = slave_word_valid_i && (master_rsv_q != slave_reserved_i);
	assign err_set = err_det_q && mismatch;

	// an error in the clear cycle survives: set wins over clear
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			err_flag_q <= 1'b0;
		end else if (err_set) begin
			err_flag_q <= 1'b1;
		end else if (err_clear) begin
			err_flag_q <= 1'b0;
		end else if (!err_sticky_q && slave_word_valid_i) begin
			err_flag_q <= 1'b0;
		end else if (!err_det_q && !err_sticky_q) begin
			err_flag_q <= 1'b0;
		end
	end

	assign error_pin_o = err_flag_q;

	// ****************************************************************
	// diagnostic capture
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			capture_q <= RST_CAPTURE;
		end else if (slave_word_valid_i && master_rsv_q && !slave_reserved_i) begin
			// detect enable is not consulted, so diagnosis works with the pin quiet
			capture_q <= {master_byte_q, slave_byte_i};
		end
	end

endmodule : stereo_serial_link_control

// ===== test/stereo_link_chk.sv
// Purpose: port-level assertions for the stereo serial link control block
// Assumes: one clock, synchronous active-high reset
// Notes: mirrors the error control bits from the register writes
`timescale 1ns/100ps
module stereo_link_chk
	import stereo_link_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [REG_W-1:0] reg_wdata_i,
	input wire logic reg_rd_i,
	input wire logic [REG_W-1:0] reg_rdata_o,
	input wire logic reg_rvalid_o,
	input wire logic slave_word_valid_i,
	input wire logic [GAIN_W-1:0] automatic_gain_loop_i,
	input wire logic serial_pixel_out_pair_o,
	input wire logic error_pin_o
);
	logic det_q;
	logic sticky_q;
	logic ctl_wr;
	assign ctl_wr = reg_wr_i && reg_addr_i == OFS_ERR_CTRL;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			det_q <= 1'b0;
			sticky_q <= 1'b0;
		end else if (ctl_wr) begin
			det_q <= reg_wdata_i[ERR_DET_BIT];
			sticky_q <= reg_wdata_i[ERR_STICKY_BIT];
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// ****
	// assertions
	// ****
	read_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
		else $error("read not answered");
	flag_mirror_a: assert property (reg_rd_i && reg_addr_i == OFS_ERR_STAT
		|=> reg_rdata_o == 16'($past(error_pin_o))) else $error("status differs from pin");
	gain_track_a: assert property (reg_rd_i && reg_addr_i == OFS_GAIN
		&& !$past(sys_rst_i)
		|=> reg_rdata_o == 16'($past(automatic_gain_loop_i, 2))) else $error("gain status");
	detect_gate_a: assert property ($rose(error_pin_o)
		|-> $past(det_q) && $past(slave_word_valid_i)) else $error("flag set without detect");
	sticky_hold_a: assert property (error_pin_o && sticky_q && det_q && !ctl_wr
		|=> error_pin_o) else $error("sticky flag dropped");
	clear_flag_a: assert property (ctl_wr && reg_wdata_i[ERR_CLEAR_BIT]
		&& !slave_word_valid_i
		|=> !error_pin_o) else $error("clear ignored");
	flag_drop_a: assert property (!sticky_q && !det_q && !ctl_wr |=> !error_pin_o)
		else $error("flag held with detect off");
	bit_slot_a: assert property ($changed(serial_pixel_out_pair_o)
		|=> $stable(serial_pixel_out_pair_o)[*3]) else $error("bit slot too short");
endmodule : stereo_link_chk

bind stereo_serial_link_control stereo_link_chk u_chk (.clk_i, .sys_rst_i, .reg_addr_i,
	.reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .slave_word_valid_i,
	.automatic_gain_loop_i, .serial_pixel_out_pair_o, .error_pin_o);

// ===== test/link_rx_model.sv
// Purpose: receiving deserializer at the far end of the serial pixel line
// Assumes: start bit high, payload msb first, stop bit, idle low
// Notes: samples mid-slot; misframes if started inside a word
`timescale 1ns/100ps
module link_rx_model
	import stereo_link_pkg::*;
(
	input wire logic clk_i,
	input wire logic serial_i,
	output logic [PIX_W-1:0] word_o,
	output logic stop_o,
	output int count_o
);
	logic [PIX_W:0] sh;
	initial begin
		count_o = 0;
		word_o = '0;
		stop_o = 1'b0;
		sh = '0;
		forever begin
			@(posedge clk_i iff serial_i === 1'b1);
			repeat (SHIFT_DIV / 2) @(posedge clk_i);
			for (int i = 0; i <= PIX_W; i++) begin
				repeat (SHIFT_DIV) @(posedge clk_i);
				sh = {sh[PIX_W-1:0], serial_i};
			end
			word_o = sh[PIX_W:1];
			stop_o = sh[0];
			count_o = count_o + 1;
		end
	end
endmodule : link_rx_model

// ===== test/stereo_serial_link_control_tb.sv
// Purpose: self-checking bench for the stereo serial link control block
// Assumes: inputs driven 1 ns after the rising edge
// Notes: random pixels come from a fixed seed
`timescale 1ns/100ps
module stereo_serial_link_control_tb
	import stereo_link_pkg::*;
;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [7:0] reg_addr_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic [REG_W-1:0] reg_wdata_i = 16'h0000;
	logic reg_rd_i = 1'b0;
	logic [REG_W-1:0] reg_rdata_o;
	logic reg_rvalid_o;
	logic [PIX_W-1:0] pix_data_i = 10'h000;
	logic pix_line_start_i = 1'b0;
	logic pix_valid_i = 1'b0;
	logic pix_ready_o;
	logic [BYTE_W-1:0] slave_byte_i = 8'h00;
	logic slave_reserved_i = 1'b0;
	logic slave_word_valid_i = 1'b0;
	logic [GAIN_W-1:0] automatic_gain_loop_i = 7'h05;
	logic serial_pixel_out_pair_o;
	logic error_pin_o;
	logic [PIX_W-1:0] rx_word;
	logic rx_stop;
	int rx_cnt;
	int err_count = 0;
	int tests_run = 0;
	int seed = 32'h561a;
	int cycles = 0;
	int t0, t, n;
	logic [REG_W-1:0] rd;
	logic [PIX_W-1:0] pix [16];

	stereo_serial_link_control u_dut (.clk_i, .sys_rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
		.reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .pix_data_i, .pix_line_start_i, .pix_valid_i,
		.pix_ready_o, .slave_byte_i, .slave_reserved_i, .slave_word_valid_i,
		.automatic_gain_loop_i, .serial_pixel_out_pair_o, .error_pin_o);
	link_rx_model u_rx (.clk_i, .serial_i(serial_pixel_out_pair_o), .word_o(rx_word),
		.stop_o(rx_stop), .count_o(rx_cnt));

	initial forever #5 clk_i = ~clk_i;
	// hang guard, well above the few thousand cycles the run needs
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			finish_test();
		end
	end

	// ****
	// tasks
	// ****
	task automatic tick(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask : tick
	task automatic check(input logic [REG_W-1:0] seen, input logic [REG_W-1:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic do_reset();
		sys_rst_i = 1'b1;
		tick(4);
		sys_rst_i = 1'b0;
	endtask : do_reset
	task automatic reg_write(input logic [7:0] a, input logic [REG_W-1:0] d);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		tick(1);
		reg_wr_i = 1'b0;
		tick(1);
	endtask : reg_write
	task automatic reg_read(input logic [7:0] a, output logic [REG_W-1:0] d);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		tick(1);
		reg_rd_i = 1'b0;
		d = reg_rdata_o;
		tick(1);
	endtask : reg_read
	task automatic slave(input logic r);
		slave_byte_i = 8'($random(seed));
		slave_reserved_i = r;
		slave_word_valid_i = 1'b1;
		tick(1);
		slave_word_valid_i = 1'b0;
		tick(1);
	endtask : slave
	function automatic logic [PIX_W-1:0] exp_word(input logic [PIX_W-1:0] p, input logic ls,
		input logic ten);
		if (!ten) return {p[9:2], ls, 1'b1};
		if (ls) return RSV_CODE;
		return (p == RSV_CODE) ? CLIP_CODE : p;
	endfunction : exp_word
	task automatic finish_test();
		$display("TB: checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test

	// ****
	// sequence
	// ****
	initial begin
		do_reset();
		reg_read(OFS_GAIN, rd);
		check(rd, 16'h0010);
		for (int a = OFS_LATENCY; a <= OFS_CAPTURE; a++) begin
			reg_read(8'(a), rd);
			check(rd, 16'h0000);
		end
		for (int a = OFS_LATENCY; a <= OFS_ERR_CTRL; a++) begin
			reg_write(8'(a), 16'hffff);
			reg_read(8'(a), rd);
			check(rd, (a == OFS_LATENCY || a == OFS_ERR_CTRL) ? 16'h0003 : 16'h0001);
			reg_write(8'(a), 16'h0000);
		end
		automatic_gain_loop_i = 7'($random(seed));
		reg_write(OFS_GAIN, 16'h0000);
		reg_read(OFS_GAIN, rd);
		check(rd, 16'(automatic_gain_loop_i));
		$display("TB: registers done");
		for (int l = 0; l < 4; l++) begin
			do_reset();
			reg_write(OFS_LATENCY, 16'(l));
			reg_write(OFS_SYNC, 16'h0001);
			for (t = 0; t < 200 && serial_pixel_out_pair_o !== 1'b1; t++) tick(1);
			if (l == 0) t0 = t;
			check(16'(t - t0), 16'(SHIFT_DIV * l));
			n = 0;
			for (int k = 0; k < 2 * WORD_BITS * SHIFT_DIV; k++) begin
				n += (serial_pixel_out_pair_o === 1'b1);
				tick(1);
			end
			check(16'(n), 16'(2 * SHIFT_DIV));
		end
		$display("TB: latency and sync done");
		for (int ten = 1; ten >= 0; ten--) begin
			do_reset();
			// let the receiver finish any word cut short by the reset
			tick(SHIFT_DIV * WORD_BITS);
			reg_write(OFS_PAYLOAD, 16'(ten));
			reg_write(OFS_SYNC, 16'h0001);
			// odd pixels only, so no data word can pass for a sync word
			for (int i = 0; i < 16; i++) pix[i] = 10'($random(seed)) | 10'h001;
			pix[0] = 10'h3ff;
			n = 0;
			pix_valid_i = 1'b1;
			for (int i = 0; i < 20; i++) begin
				pix_data_i = pix[n[3:0]];
				pix_line_start_i = (n == 15);
				if (pix_ready_o === 1'b1) n++;
				tick(1);
			end
			pix_valid_i = 1'b0;
			check(16'(n), 16'h0010);
			check(16'(pix_ready_o), 16'h0000);
			reg_write(OFS_SYNC, 16'h0000);
			n = 0;
			t = rx_cnt;
			for (int k = 0; k < 2000 && n < 16; k++) begin
				tick(1);
				if (rx_cnt != t && (rx_word != 0 || n > 0)) begin
					check(16'({rx_stop, rx_word}), 16'(exp_word(pix[n], n == 15, 1'(ten))));
					n++;
				end
				t = rx_cnt;
			end
			check(16'(n), 16'h0010);
		end
		$display("TB: payload done");
		slave(1'b0);
		check(16'(error_pin_o), 16'h0000);
		reg_read(OFS_CAPTURE, rd);
		check(rd, {pix[15][9:2], slave_byte_i});
		t0 = rd;
		slave(1'b1);
		reg_read(OFS_CAPTURE, rd);
		check(rd, 16'(t0));
		reg_write(OFS_ERR_CTRL, 16'h0001);
		slave(1'b0);
		reg_read(OFS_ERR_STAT, rd);
		check(rd, 16'h0001);
		check(16'(error_pin_o), 16'h0001);
		slave(1'b1);
		check(16'(error_pin_o), 16'h0000);
		reg_write(OFS_ERR_CTRL, 16'h0003);
		slave(1'b0);
		slave(1'b1);
		check(16'(error_pin_o), 16'h0001);
		// detect and sticky both off: a held flag must drop at once
		reg_write(OFS_ERR_CTRL, 16'h0000);
		check(16'(error_pin_o), 16'h0000);
		reg_write(OFS_ERR_CTRL, 16'h0003);
		slave(1'b0);
		check(16'(error_pin_o), 16'h0001);
		reg_write(OFS_ERR_CTRL, 16'h0007);
		reg_read(OFS_ERR_STAT, rd);
		check(rd, 16'h0000);
		$display("TB: stereo error done");
		finish_test();
	end
endmodule : stereo_serial_link_control_tb
